//--- ldp_pkg.sv
package ldp_pkg;
  localparam logic [7:0] OFS_PWM_DUTY   = 8'h00;
  localparam logic [7:0] OFS_MODE       = 8'h01;
  localparam logic [7:0] OFS_DC_LEVEL   = 8'h07;
  localparam logic [7:0] OFS_CONV_CFG   = 8'h08;
  localparam logic [7:0] OFS_CHAN_MASK  = 8'h09;
  localparam logic [7:0] OFS_PHASE      = 8'h0A;
  localparam logic [7:0] OFS_ALT_SW     = 8'h7F;

  localparam logic [7:0] RST_PWM_DUTY   = 8'hFF;
  localparam logic [7:0] RST_MODE       = 8'h01;
  localparam logic [7:0] RST_DC_LEVEL   = 8'hFF;
  localparam logic [7:0] RST_CONV_CFG   = 8'h00;
  localparam logic [7:0] RST_CHAN_MASK  = 8'h00;
  localparam logic [7:0] RST_PHASE      = 8'h00;
  localparam logic [7:0] RST_ALT_SW     = 8'h00;

  localparam logic [7:0] MODE_REG_ONLY  = 8'h05;
  localparam logic [7:0] MODE_EXT_ONLY  = 8'h03;
  localparam logic [7:0] MODE_PRODUCT   = 8'h01;
  localparam logic [7:0] ALT_SW_800K    = 8'h80;
  localparam int         CFG_SW_SEL_BIT = 2;
  localparam int         EVEN_SPACE_BIT = 7;

  localparam logic [7:0] STEPS_PER_PER  = 8'hFF;   // 255 steps per dimming period
  localparam logic [7:0] LAST_STEP      = 8'hFE;
  localparam int         NUM_CHAN       = 6;

  localparam int         CLK_PERIOD_NS  = 100;
  localparam int         LOW_LIMIT_US   = 30500;   // 30.5 ms
  localparam int         LOW_LIMIT_CYC  = LOW_LIMIT_US * 1000 / CLK_PERIOD_NS;
  localparam logic [6:0] DEV_ADDR       = 7'h2C;   // arbitrary bus address

  typedef enum logic [1:0] {
    SW_600K,
    SW_1M2,
    SW_800K
  } ldp_sw_freq_t;

  // per-period snapshot of dimming settings
  typedef struct packed {
    logic [7:0] duty;
    logic [7:0] phase;
    logic [5:0] mask;
  } ldp_dim_cfg_t;
endpackage

//--- ldp_dimming.sv
// dimming pwm generator with phase control and two-wire register port
module ldp_dimming
  import ldp_pkg::*;
#(
  parameter int LOW_TIMEOUT_CYCLES = LOW_LIMIT_CYC
) (
  input  wire logic       clock_in,          // 10 MHz clock
  input  wire logic       srst_in,           // sync reset, active high
  input  wire logic       scl_in,            // bus clock pin level
  input  wire logic       sda_in,            // bus data pin level
  output logic            sda_out,           // bus data drive value, always 0
  output logic            sda_oe_out,        // bus data pulled low when high
  input  wire logic       ext_pwm_in,        // external pwm input
  input  wire logic       freq_pin_vdc_in,   // dimming_freq_pin tied to supply
  input  wire logic [7:0] step_len_in,       // clocks per 1/255 period step
  output logic [5:0]      chan_on_out,       // per-channel current enable
  output logic [7:0]      dc_level_out,      // dc level code to current sinks
  output ldp_sw_freq_t    sw_freq_out,       // boost switching frequency
  output logic            direct_mode_out,   // direct pwm mode strapped
  output logic            shutdown_out       // external low timeout shutdown
);

  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_REG, I_WR, I_ACK, I_RD, I_RACK} ldp_bus_st_t;

  // register storage
  logic [7:0]   pwm_duty_brightness;
  logic [7:0]   dimming_mode_control;
  logic [7:0]   dc_current_level;
  logic [7:0]   converter_configuration;
  logic [7:0]   channel_mask;
  logic [7:0]   channel_phase_delay;
  logic [7:0]   alt_switching_select;

  // bus slave state
  ldp_bus_st_t  bus_st;
  logic         after_rd;
  logic         ptr_set;
  logic [3:0]   bit_cnt;
  logic [7:0]   shreg;
  logic [7:0]   reg_ptr;
  logic         scl_q;
  logic         sda_q;
  logic         bus_start;
  logic         bus_stop;
  logic         scl_rise;
  logic         scl_fall;
  logic         wr_fire;
  logic [7:0]   rd_data;

  // dimming state
  logic         direct_mode;
  logic [7:0]   step_cnt;
  logic [7:0]   phase_cnt;
  logic         step_tick;
  logic         period_start;
  ldp_dim_cfg_t cfg;
  ldp_dim_cfg_t next_cfg;
  logic [15:0]  prod;
  logic [7:0]   ext_duty;

  // external pwm measurement
  logic         ext_q;
  logic [19:0]  hi_cnt;
  logic [19:0]  per_cnt;
  logic [19:0]  div_den;
  logic [20:0]  div_rem;
  logic [7:0]   div_quo;
  logic [3:0]   div_cnt;
  logic         div_busy;
  logic [18:0]  low_cnt;
  logic         ext_used;

  // phase placement
  logic [2:0]   n_chan;
  logic [7:0]   even_step;
  logic [7:0]   gap;
  logic [5:0]   chan_on;

  function automatic logic [2:0] pop6(input logic [5:0] v);
    logic [2:0] s;
    s = 3'd0;
    for (int k = 0; k < NUM_CHAN; k++) begin
      s = s + {2'b00, v[k]};
    end
    return s;
  endfunction

  // bus pin edge and condition detection
  assign bus_start = scl_in && scl_q && sda_q && !sda_in;
  assign bus_stop  = scl_in && scl_q && !sda_q && sda_in;
  assign scl_rise  = scl_in && !scl_q;
  assign scl_fall  = !scl_in && scl_q;
  assign wr_fire   = scl_fall && bus_st == I_WR && bit_cnt == 4'd8 && !direct_mode;
  assign sda_out   = 1'b0;

  // read data mux, unmapped offsets read zero
  always_comb begin
    unique case (reg_ptr)
      OFS_PWM_DUTY:  rd_data = pwm_duty_brightness;
      OFS_MODE:      rd_data = dimming_mode_control;
      OFS_DC_LEVEL:  rd_data = dc_current_level;
      OFS_CONV_CFG:  rd_data = converter_configuration;
      OFS_CHAN_MASK: rd_data = channel_mask;
      OFS_PHASE:     rd_data = channel_phase_delay;
      OFS_ALT_SW:    rd_data = alt_switching_select;
      default:       rd_data = 8'h00;
    endcase
  end

  // pin history for edge detection
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      ext_q <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      ext_q <= ext_pwm_in;
    end
  end

  // two-wire slave: address, pointer, then write or read bytes
  always_ff @(posedge clock_in) begin
    if (srst_in || direct_mode) begin
      bus_st     <= I_IDLE;
      after_rd   <= 1'b0;
      ptr_set    <= 1'b0;
      bit_cnt    <= 4'd0;
      shreg      <= 8'h00;
      reg_ptr    <= 8'h00;
      sda_oe_out <= 1'b0;
    end else if (bus_start) begin
      bus_st     <= I_ADDR;
      ptr_set    <= 1'b0;
      bit_cnt    <= 4'd0;
      sda_oe_out <= 1'b0;
    end else if (bus_stop) begin
      bus_st     <= I_IDLE;
      sda_oe_out <= 1'b0;
    end else if (scl_rise) begin
      unique case (bus_st)
        I_ADDR, I_REG, I_WR: begin
          shreg   <= {shreg[6:0], sda_in};
          bit_cnt <= bit_cnt + 4'd1;
        end
        I_RD:    bit_cnt <= bit_cnt + 4'd1;
        I_RACK:  bus_st <= sda_in ? I_IDLE : I_ACK;   // master nack ends read
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (bus_st)
        I_ADDR: if (bit_cnt == 4'd8) begin
          if (shreg[7:1] == DEV_ADDR) begin
            sda_oe_out <= 1'b1;
            after_rd   <= shreg[0];
            bus_st     <= I_ACK;
          end else begin
            bus_st <= I_IDLE;
          end
        end
        I_REG: if (bit_cnt == 4'd8) begin
          reg_ptr    <= shreg;
          sda_oe_out <= 1'b1;
          ptr_set    <= 1'b1;
          bus_st     <= I_ACK;
        end
        I_WR: if (bit_cnt == 4'd8) begin
          reg_ptr    <= reg_ptr + 8'h01;
          sda_oe_out <= 1'b1;
          bus_st     <= I_ACK;
        end
        I_ACK: begin
          bit_cnt <= 4'd0;
          if (after_rd) begin
            shreg      <= rd_data;
            sda_oe_out <= !rd_data[7];
            bus_st     <= I_RD;
          end else begin
            sda_oe_out <= 1'b0;
            bus_st     <= ptr_set ? I_WR : I_REG;   // pointer byte comes first
          end
        end
        I_RD: if (bit_cnt == 4'd8) begin
          sda_oe_out <= 1'b0;
          reg_ptr    <= reg_ptr + 8'h01;
          bus_st     <= I_RACK;
        end else begin
          shreg      <= {shreg[6:0], 1'b0};
          sda_oe_out <= !shreg[6];
        end
        default: ;
      endcase
    end
  end

  // register writes; dc level applies immediately
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pwm_duty_brightness     <= RST_PWM_DUTY;
      dimming_mode_control    <= RST_MODE;
      dc_current_level        <= RST_DC_LEVEL;
      converter_configuration <= RST_CONV_CFG;
      channel_mask            <= RST_CHAN_MASK;
      channel_phase_delay     <= RST_PHASE;
      alt_switching_select    <= RST_ALT_SW;
    end else if (wr_fire) begin
      unique case (reg_ptr)
        OFS_PWM_DUTY:  pwm_duty_brightness     <= shreg;
        OFS_MODE:      dimming_mode_control    <= shreg;
        OFS_DC_LEVEL:  dc_current_level        <= shreg;
        OFS_CONV_CFG:  converter_configuration <= shreg;
        OFS_CHAN_MASK: channel_mask            <= shreg;
        OFS_PHASE:     channel_phase_delay     <= shreg;
        OFS_ALT_SW:    alt_switching_select    <= shreg;
        default:       ;
      endcase
    end
  end

  // strap caught while reset is held
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      direct_mode <= freq_pin_vdc_in && !scl_in && !sda_in;
    end
  end

  // step prescaler and 255-step period counter
  assign step_tick    = step_cnt >= ((step_len_in == 8'h00) ? 8'h00 : step_len_in - 8'h01);
  assign period_start = step_tick && phase_cnt == LAST_STEP;
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      step_cnt  <= 8'h00;
      phase_cnt <= 8'h00;
    end else if (step_tick) begin
      step_cnt  <= 8'h00;
      phase_cnt <= (phase_cnt == LAST_STEP) ? 8'h00 : phase_cnt + 8'h01;
    end else begin
      step_cnt <= step_cnt + 8'h01;
    end
  end

  // external duty: high time over period as fraction of 256, serial divide
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      hi_cnt   <= 20'h0_0000;
      per_cnt  <= 20'h0_0000;
      div_den  <= 20'h0_0000;
      div_rem  <= 21'h00_0000;
      div_quo  <= 8'h00;
      div_cnt  <= 4'd0;
      div_busy <= 1'b0;
      ext_duty <= 8'hFF;
    end else begin
      if (ext_pwm_in && !ext_q) begin
        hi_cnt   <= 20'h0_0001;                                  // edge cycle is high too
        per_cnt  <= 20'h0_0001;
        div_den  <= per_cnt;
        div_rem  <= {1'b0, hi_cnt};
        div_quo  <= 8'h00;
        div_cnt  <= 4'd0;
        div_busy <= per_cnt != 20'h0_0000;
      end else begin
        if (per_cnt != 20'hF_FFFF) begin
          per_cnt <= per_cnt + 20'h0_0001;
        end else if (ext_pwm_in) begin
          ext_duty <= 8'hFF;                                     // held high
        end
        if (ext_pwm_in && hi_cnt != 20'hF_FFFF) begin
          hi_cnt <= hi_cnt + 20'h0_0001;
        end
        if (div_busy) begin
          if ({div_rem[19:0], 1'b0} >= {1'b0, div_den}) begin
            div_rem <= {div_rem[19:0], 1'b0} - {1'b0, div_den};
            div_quo <= {div_quo[6:0], 1'b1};
          end else begin
            div_rem <= {div_rem[19:0], 1'b0};
            div_quo <= {div_quo[6:0], 1'b0};
          end
          div_cnt  <= div_cnt + 4'd1;
          div_busy <= div_cnt != 4'd7;                           // eight quotient bits
        end else if (div_cnt == 4'd8) begin
          ext_duty <= (div_den == 20'h0_0000) ? 8'hFF : div_quo;
          div_cnt  <= 4'd0;
        end
      end
    end
  end

  // low-time watchdog on external pwm when its duty is in use
  assign ext_used = !direct_mode && dimming_mode_control != MODE_REG_ONLY;
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      low_cnt      <= 19'h0_0000;
      shutdown_out <= 1'b0;
    end else if (ext_pwm_in || !ext_used) begin
      low_cnt <= 19'h0_0000;
    end else if (low_cnt >= 19'(LOW_TIMEOUT_CYCLES - 1)) begin
      shutdown_out <= 1'b1;
    end else begin
      low_cnt <= low_cnt + 19'h0_0001;
    end
  end

  // duty source selection, sampled at each period start
  assign prod = pwm_duty_brightness * ext_duty;
  always_comb begin
    next_cfg.phase = channel_phase_delay;
    next_cfg.mask  = channel_mask[5:0];
    unique case (dimming_mode_control)
      MODE_REG_ONLY: next_cfg.duty = pwm_duty_brightness;
      MODE_EXT_ONLY: next_cfg.duty = ext_duty;
      default:       next_cfg.duty = prod[15:8];
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cfg <= '{duty: RST_PWM_DUTY, phase: RST_PHASE, mask: RST_CHAN_MASK[5:0]};
    end else if (period_start) begin
      cfg <= next_cfg;
    end
  end

  // operating channel count and even spacing step floor(255/N)
  assign n_chan = pop6(~cfg.mask);
  always_comb begin
    unique case (n_chan)
      3'd2:    even_step = 8'd127;
      3'd3:    even_step = 8'd85;
      3'd4:    even_step = 8'd63;
      3'd5:    even_step = 8'd51;
      3'd6:    even_step = 8'd42;
      default: even_step = STEPS_PER_PER;
    endcase
    gap = cfg.phase[EVEN_SPACE_BIT] ? even_step : {1'b0, cfg.phase[6:0]};
  end

  // per-channel window shifted by rank times gap, wrapped on the period
  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
    logic [2:0]  rank;
    logic [10:0] raw_off;
    logic [7:0]  off;
    logic [7:0]  pos;
    assign rank    = pop6(~cfg.mask & ((6'h01 << i) - 6'h01));
    assign raw_off = direct_mode ? 11'h000 : 11'(rank * gap);
    assign off     = (raw_off >= 11'd510) ? 8'(raw_off - 11'd510) :
                     (raw_off >= 11'd255) ? 8'(raw_off - 11'd255) : raw_off[7:0];
    assign pos     = (phase_cnt >= off) ? phase_cnt - off : phase_cnt + (STEPS_PER_PER - off);
    assign chan_on[i] = !cfg.mask[i] && pos < cfg.duty;
  end

  // channel drive, dc level and boost frequency outputs
  always_ff @(posedge clock_in) begin
    if (srst_in || shutdown_out || dc_current_level == 8'h00) begin
      chan_on_out <= 6'h00;
    end else if (direct_mode) begin
      chan_on_out <= {NUM_CHAN{ext_pwm_in}};
    end else begin
      chan_on_out <= chan_on;
    end
  end

  assign dc_level_out    = dc_current_level;
  assign direct_mode_out = direct_mode;
  assign sw_freq_out     = (alt_switching_select == ALT_SW_800K) ? SW_800K :
                           converter_configuration[CFG_SW_SEL_BIT] ? SW_1M2 : SW_600K;

endmodule

//--- ldp_dimming_sva.sv
// port assertions for the dimming block
module ldp_dimming_sva
  import ldp_pkg::*;
#(
  parameter int LOW_TIMEOUT_CYCLES = LOW_LIMIT_CYC
) (
  input wire logic         clock_in,         // clock
  input wire logic         srst_in,          // reset
  input wire logic         scl_in,           // bus clock
  input wire logic         sda_in,           // bus data
  input wire logic         sda_out,          // data value
  input wire logic         sda_oe_out,       // data pull
  input wire logic         ext_pwm_in,       // external pwm
  input wire logic         freq_pin_vdc_in,  // strap
  input wire logic [7:0]   step_len_in,      // step length
  input wire logic [5:0]   chan_on_out,      // channels
  input wire logic [7:0]   dc_level_out,     // dc level
  input wire ldp_sw_freq_t sw_freq_out,      // switching freq
  input wire logic         direct_mode_out,  // direct mode
  input wire logic         shutdown_out      // shutdown
);
  timeunit 1ns;
  timeprecision 1ns;
  int low_cnt;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (srst_in);
  // run of consecutive low samples on the external pwm
  always_ff @(posedge clock_in) begin
    if (srst_in || ext_pwm_in) begin
      low_cnt <= 0;
    end else if (low_cnt < LOW_TIMEOUT_CYCLES + 8) begin
      low_cnt <= low_cnt + 1;
    end
  end
  // first edge after a reset
  sequence s_fresh;
    $past(srst_in);
  endsequence
  // dc level zero long enough to reach the output register
  sequence s_dc_off;
    (dc_level_out == 8'h00) [*2];
  endsequence
  // direct mode settled past reset
  sequence s_direct;
    !$past(srst_in) && direct_mode_out;
  endsequence
  a_dc_dark: assert property (s_dc_off |-> chan_on_out == 6'h00)
    else $error("channels on with dc level zero");
  a_shut_dark: assert property (shutdown_out [*2] |-> chan_on_out == 6'h00)
    else $error("channels on during shutdown");
  a_shut_sticky: assert property (shutdown_out |=> shutdown_out)
    else $error("shutdown released without reset");
  a_shut_cause: assert property ($rose(shutdown_out) |->
    low_cnt >= LOW_TIMEOUT_CYCLES - 1 && !direct_mode_out)
    else $error("shutdown without long low input");
  a_direct_follow: assert property (s_direct |->
    chan_on_out == {6{$past(ext_pwm_in)}})
    else $error("direct mode output not following input");
  a_strap_held: assert property (!$past(srst_in) |-> $stable(direct_mode_out))
    else $error("direct mode strap changed after reset");
  a_reset_levels: assert property (s_fresh |->
    dc_level_out == 8'hff && sw_freq_out == SW_600K)
    else $error("wrong levels after reset");
  a_reset_dark: assert property (s_fresh |->
    chan_on_out == 6'h00 && !sda_oe_out && !shutdown_out)
    else $error("outputs active right after reset");
  a_oe_steady: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_out))
    else $error("data pull changed while bus clock high");
  a_sda_drive: assert property (sda_out == 1'b0)
    else $error("data drive value not zero");
endmodule

//--- ldp_host_model.sv
// bus host and external pwm source for the dimming block
module ldp_host_model
  import ldp_pkg::*;
(
  input  wire logic clock_in,     // system clock
  input  wire logic sda_in,       // resolved data line
  output logic      scl_out,      // bus clock level
  output logic      sda_low_out,  // pulls data low when high
  output logic      pwm_out       // external pwm
);
  timeunit 1ns;
  timeprecision 1ns;
  int hi_c = 0;
  int per_c = 0;
  int cnt = 0;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    pwm_out = 1'b1;
  end
  // pwm source, static level when the period is zero
  always @(negedge clock_in) begin
    if (per_c == 0) begin
      pwm_out <= (hi_c != 0);
    end else begin
      pwm_out <= (cnt < hi_c);
      cnt <= (cnt + 1) % per_c;
    end
  end
  task automatic set_pwm(input int hi, input int per);
    hi_c = hi;
    per_c = per;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  // both bus lines grounded for the direct strap
  task automatic strap(input logic on);
    scl_out = ~on;
    sda_low_out = on;
  endtask
  // one bit slot, line level taken while the clock is high
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = ~b;
    tick(2);
    scl_out = 1'b1;
    tick(2);
    r = sda_in;
    tick(1);
    scl_out = 1'b0;
    tick(1);
  endtask
  task automatic xfer(input logic [7:0] b, output logic [7:0] r, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r[i]);
    end
    bit_io(1'b1, nak);
  endtask
  task automatic start();
    sda_low_out = 1'b0;
    tick(1);
    scl_out = 1'b1;
    tick(2);
    sda_low_out = 1'b1;
    tick(2);
    scl_out = 1'b0;
    tick(1);
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    tick(1);
    scl_out = 1'b1;
    tick(2);
    sda_low_out = 1'b0;
    tick(2);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic nak);
    logic [7:0] r;
    logic       n0, n1, n2;
    start();
    xfer({DEV_ADDR, 1'b0}, r, n0);
    xfer(p, r, n1);
    xfer(d, r, n2);
    stop();
    nak = n0 | n1 | n2;
  endtask
  // pointer write, repeated start, one byte ended by nack
  task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic nak);
    logic [7:0] r;
    logic       n0, n1, n2, n3;
    start();
    xfer({DEV_ADDR, 1'b0}, r, n0);
    xfer(p, r, n1);
    start();
    xfer({DEV_ADDR, 1'b1}, r, n2);
    xfer(8'hff, d, n3);
    stop();
    nak = n0 | n1 | n2 | ~n3;
  endtask
endmodule

//--- ldp_tb.sv
// self-checking bench for the dimming block
module tb
  import ldp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOWT = 300;
  // mode, register duty, expected high count per period
  localparam logic [23:0] ROWS [6] = '{24'h05_ffff, 24'h05_0000, 24'h05_6464,
                                      24'h03_6480, 24'h01_c864, 24'h01_3319};
  // offset, value, expected switching frequency code
  localparam logic [23:0] SWR [4] = '{24'h08_0401, 24'h7f_8002, 24'h7f_8101, 24'h08_0000};
  logic         clock_in;
  logic         srst_in;
  logic         fvdc;
  logic [7:0]   step_len;
  logic         scl;
  logic         sda_low;
  logic         sda_w;
  logic         pwm;
  logic         oe;
  logic [5:0]   chan;
  logic [7:0]   dcl;
  ldp_sw_freq_t swf;
  logic         dmode;
  logic         shut;
  logic [5:0]   prev_c;
  logic         nak;
  logic [7:0]   rdat;
  logic [15:0]  g;
  logic [15:0]  c;
  int           err_total = 0;
  int           checks_done = 0;
  ldp_dimming #(.LOW_TIMEOUT_CYCLES(LOWT)) dut (
    .clock_in        (clock_in),
    .srst_in         (srst_in),
    .scl_in          (scl),
    .sda_in          (sda_w),
    .sda_out         (),
    .sda_oe_out      (oe),
    .ext_pwm_in      (pwm),
    .freq_pin_vdc_in (fvdc),
    .step_len_in     (step_len),
    .chan_on_out     (chan),
    .dc_level_out    (dcl),
    .sw_freq_out     (swf),
    .direct_mode_out (dmode),
    .shutdown_out    (shut)
  );
  ldp_host_model host (.clock_in(clock_in), .sda_in(sda_w), .scl_out(scl),
                       .sda_low_out(sda_low), .pwm_out(pwm));
  // open-drain data line with pull-up
  assign sda_w = ~(oe | sda_low);
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) begin
      prev_c = chan;
      @(negedge clock_in);
    end
  endtask
  task automatic w(input logic [7:0] p, input logic [7:0] v);
    host.wr(p, v, nak);
    chk("write_ack", 16'h0000, {15'h0, nak});
  endtask
  task automatic rg(input logic [7:0] p, input logic [15:0] exp);
    host.rd(p, rdat, nak);
    chk("read_ack", 16'h0000, {15'h0, nak});
    chk("reg_value", exp, {8'h00, rdat});
  endtask
  task automatic hcount(input int ch, input int n);
    c = 16'h0000;
    repeat (n) begin
      tk(1);
      c = c + {15'h0, chan[ch]};
    end
  endtask
  // cycles from a rising edge of channel a to the next of channel b
  task automatic gap(input int a, input int b);
    int n;
    n = 0;
    while (!(chan[a] & ~prev_c[a]) && n < 600) begin
      tk(1);
      n++;
    end
    if (n >= 600) begin
      err_total++;
      conclude();
    end
    g = 16'h0000;
    while (!(chan[b] & ~prev_c[b]) && g < 16'h0258) begin
      tk(1);
      g++;
    end
  endtask
  initial begin
    repeat (95000) @(posedge clock_in);
    err_total++;
    conclude();
  end
  initial begin
    srst_in = 1'b1;
    fvdc = 1'b0;
    step_len = 8'h01;
    prev_c = 6'h00;
    host.set_pwm(128, 256);
    repeat (8) @(negedge clock_in);
    srst_in = 1'b0;
    tk(2);
    chk("dc_level", 16'h00ff, {8'h00, dcl});
    chk("sw_freq", 16'h0000, {14'h0, swf});
    rg(8'h00, 16'h00ff);
    rg(8'h01, 16'h0001);
    rg(8'h07, 16'h00ff);
    tk(800);
    gap(0, 5);
    chk("sync_gap", 16'h0000, g);
    for (int i = 0; i < 6; i++) begin
      w(8'h01, ROWS[i][23:16]);
      w(8'h00, ROWS[i][15:8]);
      tk(800);
      hcount(0, 255);
      chk("duty_ch0", {8'h00, ROWS[i][7:0]}, c);
      hcount(5, 255);
      chk("duty_ch5", {8'h00, ROWS[i][7:0]}, c);
    end
    // phase spacing: even with six, even with four, programmed
    w(8'h00, 8'h64);
    w(8'h01, 8'h05);
    w(8'h0a, 8'h80);
    tk(800);
    gap(0, 1);
    chk("even_gap", 16'h002a, g);
    gap(5, 0);
    chk("even_wrap", 16'h002d, g);
    w(8'h09, 8'h03);
    tk(800);
    gap(2, 3);
    chk("even_gap4", 16'h003f, g);
    gap(5, 2);
    chk("even_wrap4", 16'h0042, g);
    hcount(0, 255);
    chk("masked_ch0", 16'h0000, c);
    w(8'h09, 8'h00);
    w(8'h0a, 8'h14);
    tk(800);
    gap(0, 1);
    chk("prog_gap", 16'h0014, g);
    gap(5, 0);
    chk("prog_wrap", 16'h009b, g);
    // two clocks per step doubles the dimming period
    step_len = 8'h02;
    tk(1100);
    hcount(0, 510);
    chk("slow_duty", 16'h00c8, c);
    step_len = 8'h01;
    // dc level changed on the fly, then zero
    w(8'h07, 8'hc8);
    chk("dc_level", 16'h00c8, {8'h00, dcl});
    hcount(0, 255);
    chk("duty_dc", 16'h0064, c);
    w(8'h07, 8'h00);
    tk(3);
    hcount(0, 255);
    chk("dc_zero", 16'h0000, c);
    w(8'h07, 8'hff);
    for (int i = 0; i < 4; i++) begin
      w(SWR[i][23:16], SWR[i][15:8]);
      chk("sw_freq", {14'h0, SWR[i][1:0]}, {14'h0, swf});
    end
    // unmapped offset: write acked and dropped, reads zero
    w(8'h05, 8'h5a);
    rg(8'h05, 16'h0000);
    w(8'h01, 8'h03);
    chk("no_shutdown", 16'h0000, {15'h0, shut});
    host.set_pwm(0, 0);
    tk(LOWT + 20);
    chk("shutdown", 16'h0001, {15'h0, shut});
    hcount(0, 255);
    chk("shut_dark", 16'h0000, c);
    // second reset with the direct strap
    srst_in = 1'b1;
    host.strap(1'b1);
    fvdc = 1'b1;
    tk(8);
    srst_in = 1'b0;
    host.set_pwm(30, 100);
    tk(300);
    chk("direct_mode", 16'h0001, {15'h0, dmode});
    hcount(0, 200);
    chk("direct_duty", 16'h003c, c);
    gap(0, 5);
    chk("direct_gap", 16'h0000, g);
    conclude();
  end
endmodule
bind ldp_dimming ldp_dimming_sva #(.LOW_TIMEOUT_CYCLES(LOW_TIMEOUT_CYCLES)) u_sva (
  .clock_in(clock_in), .srst_in(srst_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .ext_pwm_in(ext_pwm_in),
  .freq_pin_vdc_in(freq_pin_vdc_in), .step_len_in(step_len_in),
  .chan_on_out(chan_on_out), .dc_level_out(dc_level_out), .sw_freq_out(sw_freq_out),
  .direct_mode_out(direct_mode_out), .shutdown_out(shutdown_out)
);
